// >>> verilog/spi_cfg_pkg.sv
package spi_cfg_pkg;

   // -----------------------------------------------------------------
   // register byte offsets on the bus
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL_PRI  = 8'h00;
   localparam logic [7:0] OFS_CTRL_SEC  = 8'h04;
   localparam logic [7:0] OFS_BAUD      = 8'h08;
   localparam logic [7:0] OFS_STATUS    = 8'h0C;
   localparam logic [7:0] OFS_DATA      = 8'h10;

   // -----------------------------------------------------------------
   // values after reset and write masks
   // -----------------------------------------------------------------
   localparam logic [7:0] CTRL_PRI_RST  = 8'h04;
   localparam logic [7:0] CTRL_SEC_RST  = 8'h00;
   localparam logic [7:0] BAUD_RST      = 8'h00;
   localparam logic [7:0] CTRL_SEC_MASK = 8'h1B;
   localparam logic [7:0] BAUD_MASK     = 8'h77;
   localparam logic [3:0] PIN_RST       = 4'h1;   // {sclk, mosi, miso, ss}

   // -----------------------------------------------------------------
   // field positions, primary control
   // -----------------------------------------------------------------
   localparam int C1_RXF_IE  = 7;
   localparam int C1_ENABLE  = 6;
   localparam int C1_TXE_IE  = 5;
   localparam int C1_MASTER  = 4;
   localparam int C1_POL     = 3;
   localparam int C1_PHASE   = 2;
   localparam int C1_SS_OE   = 1;
   localparam int C1_LSB     = 0;

   // -----------------------------------------------------------------
   // field positions, secondary control, status
   // -----------------------------------------------------------------
   localparam int C2_FAULT_EN = 4;
   localparam int C2_BIDIR_OE = 3;
   localparam int C2_HALT_WT  = 1;
   localparam int C2_SINGLE   = 0;
   localparam int ST_RX_FULL  = 7;
   localparam int ST_TX_EMPTY = 5;
   localparam int ST_FAULT    = 4;

   // -----------------------------------------------------------------
   // byte framing and master sequencer
   // -----------------------------------------------------------------
   localparam logic [4:0] LAST_EDGE = 5'h0F;    // 16 edges per 8-bit byte

   typedef enum logic [1:0] {
      M_IDLE  = 2'b00,
      M_LEAD  = 2'b01,
      M_SHIFT = 2'b10,
      M_TAIL  = 2'b11
   } master_state_e;

endpackage : spi_cfg_pkg

// >>> verilog/spi_shifter.sv
module spi_shifter (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       ce_i,
   input  wire logic       clear_i,
   input  wire logic       load_i,
   input  wire logic [7:0] data_i,
   input  wire logic       edge_i,
   input  wire logic       phase_i,
   input  wire logic       low_first_i,
   input  wire logic       serial_in_i,
   output logic            serial_out_o,
   output logic [7:0]      byte_o,
   output logic            done_o
);
   import spi_cfg_pkg::*;

   logic [4:0] cnt_q;
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   logic       done_q;
   logic       lead;
   logic       sample;
   logic       shift;

   // -----------------------------------------------------------------
   // edge classification: even count is a leading edge
   // -----------------------------------------------------------------
   assign lead   = ~cnt_q[0];
   assign sample = phase_i ? ~lead : lead;
   assign shift  = phase_i ? (lead && cnt_q != 5'h00) : ~lead;

   // edge counter and done pulse
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || (ce_i && (clear_i || load_i))) begin
         cnt_q  <= 5'h00;
         done_q <= 1'b0;
      end else if (ce_i) begin
         done_q <= edge_i && cnt_q == LAST_EDGE;
         if (edge_i) begin
            cnt_q <= (cnt_q == LAST_EDGE) ? 5'h00 : cnt_q + 5'h01;
         end
      end
   end

   // transmit and receive shift paths, order set by bit-order bit
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         tx_q <= 8'h00;
         rx_q <= 8'h00;
      end else if (ce_i) begin
         if (load_i) begin
            tx_q <= data_i;
         end else if (edge_i && shift) begin
            tx_q <= low_first_i ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
         end
         if (edge_i && sample) begin
            rx_q <= low_first_i ? {serial_in_i, rx_q[7:1]}
                                : {rx_q[6:0], serial_in_i};
         end
      end
   end

   assign serial_out_o = low_first_i ? tx_q[0] : tx_q[7];
   assign byte_o       = rx_q;
   assign done_o       = done_q;

endmodule : spi_shifter

// >>> verilog/spi_pin_mux.sv
module spi_pin_mux (
   input  wire logic       enable_i,
   input  wire logic       master_i,
   input  wire logic       single_i,
   input  wire logic       bidir_oe_i,
   input  wire logic       fault_en_i,
   input  wire logic       ss_oe_i,
   input  wire logic       clk_lvl_i,
   input  wire logic       sout_i,
   input  wire logic       ss_drive_i,
   input  wire logic       mosi_s_i,
   input  wire logic       miso_s_i,
   input  wire logic       ss_s_i,
   output logic            sclk_o,
   output logic            sclk_oe_o,
   output logic            mosi_o,
   output logic            mosi_oe_o,
   output logic            miso_o,
   output logic            miso_oe_o,
   output logic            ss_o,
   output logic            ss_oe_o,
   output logic [3:0]      gpio_owned_o,
   output logic            sin_o,
   output logic            slave_sel_o,
   output logic            fault_in_o
);
   logic mst;
   logic slv;

   // -----------------------------------------------------------------
   // pin routing by role, wire mode and select options
   // -----------------------------------------------------------------
   assign mst         = enable_i && master_i;
   assign slv         = enable_i && !master_i;
   assign slave_sel_o = slv && !ss_s_i;
   assign fault_in_o  = mst && fault_en_i && !ss_oe_i && !ss_s_i;

   // clock: output in master, input in slave
   assign sclk_o    = clk_lvl_i;
   assign sclk_oe_o = mst;

   // data pins; the shared pin follows the drive-enable bit only in single-wire mode
   assign mosi_o    = sout_i;
   assign mosi_oe_o = mst && (!single_i || bidir_oe_i);
   assign miso_o    = sout_i;
   assign miso_oe_o = slave_sel_o && (!single_i || bidir_oe_i);
   assign sin_o     = (master_i ^ single_i) ? miso_s_i : mosi_s_i;

   // slave-select pin: output only with both fault enable and select output
   assign ss_o    = ss_drive_i;
   assign ss_oe_o = mst && fault_en_i && ss_oe_i;

   // pins handed back to the general port: {sclk, mosi, miso, ss}
   assign gpio_owned_o = {!enable_i,
                          !enable_i || (slv && single_i),
                          !enable_i || (mst && single_i),
                          !enable_i || (mst && !fault_en_i)};

endmodule : spi_pin_mux

// >>> verilog/spi_control_config.sv
// Function
// - receive-full or fault raises interrupt when enabled
// - disable aborts, flushes, clears receive, sets empty
// - transmit-empty raises interrupt when enabled
// - master select chooses role and pin directions
// - polarity inverts clock; sets idle level
// - phase picks first edge mid or start
// - bit order: msb or lsb first
// - master fault mode: select pin is input
// - master with fault enable and select output drives select pin
// - master without fault enable frees select pin
// - slave always uses select pin as input
// - unused secondary control bits read zero
// - single-wire: drive enable controls shared pin
// - two-wire: drive enable bit has no effect
// - single-wire uses master-out or master-in pin
// - halt-in-wait stops engine during wait
// - disabled module releases all four pins
// - receive flag clears: status read, data read
//
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
module spi_control_config (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   input  wire logic        wait_mode_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic        hready_i,
   input  wire logic [31:0] hwdata_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic        sclk_i,
   output logic             sclk_o,
   output logic             sclk_oe_o,
   input  wire logic        mosi_i,
   output logic             mosi_o,
   output logic             mosi_oe_o,
   input  wire logic        miso_i,
   output logic             miso_o,
   output logic             miso_oe_o,
   input  wire logic        ss_i,
   output logic             ss_o,
   output logic             ss_oe_o,
   output logic      [3:0]  gpio_owned_o,
   output logic             irq_o
);
   import spi_cfg_pkg::*;

   logic [7:0]    ctrl_pri_q;
   logic [7:0]    ctrl_sec_q;
   logic [7:0]    baud_q;
   logic [7:0]    txbuf_q;
   logic [7:0]    rxbuf_q;
   logic          rff_q;
   logic          tef_q;
   logic          mode_fault_flag_q;
   logic          rff_seen_q;
   logic          tef_seen_q;
   logic          mode_fault_flag_seen_q;
   logic [3:0]    pin_meta_q;
   logic [3:0]    pin_sync_q;
   logic          sclk_prev_q;
   logic          sel_prev_q;
   logic          wr_q;
   logic [7:0]    addr_q;
   logic [31:0]   rdata_q;
   master_state_e mst_q;
   logic [10:0]   div_q;
   logic          clk_lvl_q;
   logic          enable;
   logic          master;
   logic          run;
   logic          accept;
   logic          rd_acc;
   logic          tick;
   logic [10:0]   half_len;
   logic          m_start;
   logic          m_edge;
   logic          s_edge;
   logic          sel_rise;
   logic          buf_take;
   logic          sh_clear;
   logic          sout;
   logic [7:0]    rx_byte;
   logic          rx_done;
   logic          sin;
   logic          slave_sel;
   logic          fault_in;
   logic          data_wr;

   // -----------------------------------------------------------------
   // control decode
   // -----------------------------------------------------------------
   assign enable = ctrl_pri_q[C1_ENABLE];
   assign master = ctrl_pri_q[C1_MASTER];
   assign run    = ce_i && !(ctrl_sec_q[C2_HALT_WT] && wait_mode_i);

   // -----------------------------------------------------------------
   // pin input synchronisers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pin_meta_q <= PIN_RST;
         pin_sync_q <= PIN_RST;
      end else if (ce_i) begin
         pin_meta_q <= {sclk_i, mosi_i, miso_i, ss_i};
         pin_sync_q <= pin_meta_q;
      end
   end

   // -----------------------------------------------------------------
   // bus slave: zero wait state, always okay
   // -----------------------------------------------------------------
   assign accept      = hsel_i && hready_i && htrans_i[1];
   assign rd_acc      = ce_i && accept && !hwrite_i;
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = rdata_q;
   assign data_wr     = ce_i && wr_q && addr_q == OFS_DATA;

   // address phase capture and read data register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_q    <= 1'b0;
         addr_q  <= 8'h00;
         rdata_q <= 32'h0000_0000;
      end else if (ce_i) begin
         wr_q   <= accept && hwrite_i;
         addr_q <= haddr_i[7:0];
         if (rd_acc) begin
            case (haddr_i[7:0])
               OFS_CTRL_PRI: rdata_q <= {24'h00_0000, ctrl_pri_q};
               OFS_CTRL_SEC: rdata_q <= {24'h00_0000, ctrl_sec_q};
               OFS_BAUD:     rdata_q <= {24'h00_0000, baud_q};
               OFS_STATUS:   rdata_q <= {24'h00_0000, rff_q, 1'b0, tef_q, mode_fault_flag_q, 4'h0};
               OFS_DATA:     rdata_q <= {24'h00_0000, rxbuf_q};
               default:      rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // control registers, written in the data phase
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl_pri_q <= CTRL_PRI_RST;
         ctrl_sec_q <= CTRL_SEC_RST;
         baud_q     <= BAUD_RST;
      end else if (ce_i && wr_q) begin
         if (addr_q == OFS_CTRL_PRI) begin
            ctrl_pri_q <= hwdata_i[7:0];
         end
         if (addr_q == OFS_CTRL_SEC) begin
            ctrl_sec_q <= hwdata_i[7:0] & CTRL_SEC_MASK;
         end
         if (addr_q == OFS_BAUD) begin
            baud_q <= hwdata_i[7:0] & BAUD_MASK;
         end
      end
   end

   // -----------------------------------------------------------------
   // status flags: set wins over clear, disable overrides both for receive-full and transmit-empty
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rff_q       <= 1'b0;
         tef_q       <= 1'b1;
         mode_fault_flag_q      <= 1'b0;
         rff_seen_q  <= 1'b0;
         tef_seen_q  <= 1'b0;
         mode_fault_flag_seen_q <= 1'b0;
      end else if (ce_i) begin
         if (rd_acc && haddr_i[7:0] == OFS_STATUS) begin
            rff_seen_q  <= rff_q;
            tef_seen_q  <= tef_q;
            mode_fault_flag_seen_q <= mode_fault_flag_q;
         end
         if (!enable) begin
            rff_q <= 1'b0;
         end else if (rx_done) begin
            rff_q <= 1'b1;
         end else if (rd_acc && haddr_i[7:0] == OFS_DATA && rff_seen_q) begin
            rff_q      <= 1'b0;
            rff_seen_q <= 1'b0;
         end
         if (!enable || buf_take) begin
            tef_q <= 1'b1;
         end else if (data_wr && tef_seen_q) begin
            tef_q      <= 1'b0;
            tef_seen_q <= 1'b0;
         end
         if (fault_in) begin
            mode_fault_flag_q <= 1'b1;
         end else if (wr_q && addr_q == OFS_CTRL_PRI && mode_fault_flag_seen_q) begin
            mode_fault_flag_q      <= 1'b0;
            mode_fault_flag_seen_q <= 1'b0;
         end
      end
   end

   // transmit and receive buffers; a write without the status read is dropped
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         txbuf_q <= 8'h00;
         rxbuf_q <= 8'h00;
      end else if (ce_i) begin
         if (!enable) begin
            txbuf_q <= 8'h00;
         end else if (data_wr && tef_seen_q) begin
            txbuf_q <= hwdata_i[7:0];
         end
         if (enable && rx_done) begin
            rxbuf_q <= rx_byte;
         end
      end
   end

   // interrupt request from enabled flags
   assign irq_o = (ctrl_pri_q[C1_RXF_IE] && (rff_q || mode_fault_flag_q))
               || (ctrl_pri_q[C1_TXE_IE] && tef_q);

   // -----------------------------------------------------------------
   // master sequencer: select, half-bit lead, 16 edges, half-bit tail
   // -----------------------------------------------------------------
   assign half_len = 11'(({8'h00, baud_q[6:4]} + 11'h001) << baud_q[2:0]);
   assign tick     = div_q == half_len - 11'h001;
   assign m_start  = mst_q == M_IDLE && enable && master && !tef_q && !fault_in;
   assign m_edge   = mst_q == M_SHIFT && tick;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i || (run && (!enable || !master || fault_in))) begin
         mst_q     <= M_IDLE;
         div_q     <= 11'h000;
         clk_lvl_q <= 1'b0;
      end else if (run) begin
         div_q <= (tick || mst_q == M_IDLE) ? 11'h000 : div_q + 11'h001;
         if (m_edge) begin
            clk_lvl_q <= !clk_lvl_q;
         end
         case (mst_q)
            M_IDLE:  if (m_start) mst_q <= M_LEAD;
            M_LEAD:  if (tick) mst_q <= M_SHIFT;
            M_SHIFT: if (rx_done) mst_q <= M_TAIL;
            M_TAIL:  if (tick) mst_q <= M_IDLE;
            default: mst_q <= M_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // slave edge finder on the sampled serial clock
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sclk_prev_q <= 1'b0;
         sel_prev_q  <= 1'b0;
      end else if (run) begin
         sclk_prev_q <= pin_sync_q[3];
         sel_prev_q  <= slave_sel;
      end
   end

   assign s_edge   = slave_sel && sel_prev_q && pin_sync_q[3] != sclk_prev_q;
   assign sel_rise = slave_sel && !sel_prev_q;
   assign buf_take = run && (m_start || (sel_rise && !tef_q));
   assign sh_clear = !enable || fault_in || (!master && !slave_sel);

   spi_shifter u_shifter (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .ce_i        (run),
      .clear_i     (sh_clear),
      .load_i      (m_start || sel_rise),
      .data_i      (txbuf_q),
      .edge_i      (master ? m_edge : s_edge),
      .phase_i     (ctrl_pri_q[C1_PHASE]),
      .low_first_i (ctrl_pri_q[C1_LSB]),
      .serial_in_i (sin),
      .serial_out_o(sout),
      .byte_o      (rx_byte),
      .done_o      (rx_done)
   );

   spi_pin_mux u_pin_mux (
      .enable_i    (enable),
      .master_i    (master),
      .single_i    (ctrl_sec_q[C2_SINGLE]),
      .bidir_oe_i  (ctrl_sec_q[C2_BIDIR_OE]),
      .fault_en_i  (ctrl_sec_q[C2_FAULT_EN]),
      .ss_oe_i     (ctrl_pri_q[C1_SS_OE]),
      .clk_lvl_i   (clk_lvl_q ^ ctrl_pri_q[C1_POL]),
      .sout_i      (sout),
      .ss_drive_i  (mst_q == M_IDLE),
      .mosi_s_i    (pin_sync_q[2]),
      .miso_s_i    (pin_sync_q[1]),
      .ss_s_i      (pin_sync_q[0]),
      .sclk_o      (sclk_o),
      .sclk_oe_o   (sclk_oe_o),
      .mosi_o      (mosi_o),
      .mosi_oe_o   (mosi_oe_o),
      .miso_o      (miso_o),
      .miso_oe_o   (miso_oe_o),
      .ss_o        (ss_o),
      .ss_oe_o     (ss_oe_o),
      .gpio_owned_o(gpio_owned_o),
      .sin_o       (sin),
      .slave_sel_o (slave_sel),
      .fault_in_o  (fault_in)
   );

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   irq_rx_a: assert property (ctrl_pri_q[C1_RXF_IE] && (rff_q || mode_fault_flag_q) |-> irq_o)
      else $error("receive or fault interrupt missing");
   disable_flags_a: assert property (ce_i && !enable |=> !rff_q && tef_q)
      else $error("disable left flags wrong");
   irq_tx_a: assert property (!irq_o |-> !(ctrl_pri_q[C1_TXE_IE] && tef_q))
      else $error("transmit interrupt missing");
   sclk_role_a: assert property (enable |-> sclk_oe_o == master)
      else $error("clock pin direction wrong for role");
   sclk_idle_a: assert property (enable && master && mst_q == M_IDLE
                                  |-> sclk_o == ctrl_pri_q[C1_POL])
      else $error("clock not at idle level");
   first_half_a: assert property (mst_q == M_LEAD |-> sclk_o == $past(sclk_o))
      else $error("clock moved before first half bit");
   fault_set_a: assert property (ce_i && enable && master && ctrl_sec_q[C2_FAULT_EN]
      && !ctrl_pri_q[C1_SS_OE] && !pin_sync_q[0] |=> mode_fault_flag_q)
      else $error("mode fault not flagged");
   ss_output_a: assert property (enable && master && ctrl_sec_q[C2_FAULT_EN]
      && ctrl_pri_q[C1_SS_OE] |-> ss_oe_o)
      else $error("select output not driven");
   ss_release_a: assert property (enable && master && !ctrl_sec_q[C2_FAULT_EN]
      |-> gpio_owned_o[0] && !ss_oe_o)
      else $error("select pin not released");
   ctrl_reserved_a: assert property ((ctrl_sec_q & ~CTRL_SEC_MASK) == 8'h00)
      else $error("unused control bits set");
   shared_drive_a: assert property (enable && master && ctrl_sec_q[C2_SINGLE]
      |-> mosi_oe_o == ctrl_sec_q[C2_BIDIR_OE] && !miso_oe_o)
      else $error("shared pin drive wrong");
   pins_off_a: assert property (!enable |-> gpio_owned_o == 4'hF
      && !(sclk_oe_o || mosi_oe_o || miso_oe_o || ss_oe_o))
      else $error("disabled module still owns pins");

endmodule : spi_control_config

// >>> verif/spi_remote_slave.sv
module spi_remote_slave (
   input  wire logic       sclk_i,
   input  wire logic       mosi_i,
   input  wire logic       ss_n_i,
   input  wire logic       lsb_i,
   input  wire logic [7:0] tx_i,
   output logic            miso_o,
   output logic [7:0]      rx_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int n = 0;
   // first bit stands from select onward, phase zero
   always @(negedge ss_n_i) begin
      n = 0;
      miso_o = lsb_i ? tx_i[0] : tx_i[7];
   end
   // capture on the leading clock edge, order per lsb_i
   always @(posedge sclk_i) if (!ss_n_i) begin
      rx_o = lsb_i ? {mosi_i, rx_o[6+1:1]} : {rx_o[6:0], mosi_i};
      n++;
   end
   // next bit on the trailing edge
   always @(negedge sclk_i) if (!ss_n_i && n < 8) begin
      miso_o = lsb_i ? tx_i[n] : tx_i[7-n];
   end
   // a released line shows the inverse of its last level
   always @(posedge ss_n_i) miso_o = ~miso_o;
endmodule : spi_remote_slave

// >>> verif/spi_control_config_test.sv
module spi_control_config_test import spi_cfg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 0, rst_n_i = 0, hwrite = 0, lsb = 0, ss_ext = 1, wait_m = 0, hresp;
   logic [1:0]  htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic        hready, sclk, sclk_oe, mosi, mosi_oe, miso, miso_oe, ss, ss_oe, irq, s_miso;
   logic [3:0]  owned;
   logic [7:0]  rd, tx, s_tx = 0, s_rx;
   int          model[3] = '{CTRL_PRI_RST, CTRL_SEC_RST, BAUD_RST};
   int          seed = 16192, failures = 0, check_count = 0, k;
   wire         miso_pin = miso_oe ? miso : s_miso;
   wire         ss_pin = ss_oe ? ss : ss_ext;
   // clock, 50 MHz
   always #10 clk_i = ~clk_i;
   spi_control_config dut_u (.clk_i, .rst_n_i, .ce_i(1'b1), .wait_mode_i(wait_m), .hsel_i(1'b1),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready),
      .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .sclk_i(sclk_oe & sclk), .sclk_o(sclk), .sclk_oe_o(sclk_oe), .mosi_i(mosi), .mosi_o(mosi),
      .mosi_oe_o(mosi_oe), .miso_i(miso_pin), .miso_o(miso), .miso_oe_o(miso_oe), .ss_i(ss_pin),
      .ss_o(ss), .ss_oe_o(ss_oe), .gpio_owned_o(owned), .irq_o(irq));
   spi_remote_slave peer_u (.sclk_i(sclk_oe & sclk), .mosi_i(mosi), .ss_n_i(ss_pin),
      .lsb_i(lsb), .tx_i(s_tx), .miso_o(s_miso), .rx_o(s_rx));
   task automatic chk(input string name, input logic [7:0] e, input logic [7:0] s);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", name, e, s);
      end
   endtask : chk
   // one single AHB-Lite transfer, updates the register model on writes
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk_i); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge clk_i); while (hready !== 1'b1);
      rd = hrdata[7:0];
      chk("hresp", 8'h00, {7'h0, hresp});
      if (w && a < OFS_STATUS) model[a>>2] = d & (a == OFS_CTRL_SEC ? 8'h1B : 8'hFF) &
         (a == OFS_BAUD ? BAUD_MASK : 8'hFF);
   endtask : bus
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk("register", e, rd);
   endtask : rdchk
   // pin ownership and drive enables expected from the control model
   task automatic pins();
      logic [7:0] c1, c2, ow;
      c1 = 8'(model[0]);
      c2 = 8'(model[1]);
      ow = c1[6] ? {5'h0, c2[0] & !c1[4], c2[0] & c1[4], c1[4] & !c2[4]} : 8'h0F;
      #1;
      chk("owned", ow, {4'h0, owned});
      chk("miso_oe", 8'h00, {7'h0, miso_oe});
      chk("ss_oe", {7'h0, c1[6] & c1[4] & c2[4] & c1[1]}, {7'h0, ss_oe});
      chk("mosi_oe", {7'h0, c1[6] & c1[4] & (!c2[0] | c2[3])}, {7'h0, mosi_oe});
      chk("sclk_oe", {7'h0, c1[6] & c1[4]}, {7'h0, sclk_oe});
      if (c1[6] & c1[4]) chk("sclk idle", {7'h0, c1[3]}, {7'h0, sclk});
      chk("irq", {7'h0, c1[5]}, {7'h0, irq});
   endtask : pins
   task automatic results();
      if (failures == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results
   // watchdog
   initial begin
      #1000000;
      failures++;
      results();
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      for (int i = 0; i < 3; i++) rdchk(8'(i * 4), 8'(model[i]));
      rdchk(8'h20, 8'h00);
      bus(1'b1, OFS_CTRL_SEC, 8'hFF);
      rdchk(OFS_CTRL_SEC, 8'h1B);
      for (int i = 0; i < 16; i++) begin
         bus(1'b1, OFS_CTRL_SEC, 8'($random(seed)));
         bus(1'b1, OFS_CTRL_PRI, (8'($random(seed)) & 8'h7B) | 8'h04); // phase kept
         pins();
         rdchk(OFS_CTRL_PRI, 8'(model[0]));
      end
      bus(1'b1, OFS_BAUD, 8'h11);
      bus(1'b1, OFS_CTRL_SEC, 8'h12);
      for (int l = 0; l < 2; l++) begin
         lsb <= l[0];
         wait_m <= l[0]; // second byte is queued in wait mode with halt set
         s_tx <= 8'($random(seed));
         tx = 8'($random(seed));
         bus(1'b1, OFS_CTRL_PRI, 8'h52 | 8'(l) | 8'(l << 7));
         bus(1'b0, OFS_STATUS, 8'h00);
         bus(1'b1, OFS_DATA, tx);
         repeat (100) @(posedge clk_i);
         rdchk(OFS_STATUS, l ? 8'h00 : 8'hA0);
         wait_m <= 1'b0;
         k = 0;
         do begin
            bus(1'b0, OFS_STATUS, 8'h00);
            k++;
         end while (!rd[7] && k < 400);
         chk("rx full", 8'h80, {rd[7], 7'h0});
         chk("rx irq", 8'(l), {7'h0, irq});
         bus(1'b0, OFS_DATA, 8'h00);
         chk("rx data", s_tx, rd);
         chk("peer rx", tx, s_rx);
      end
      // master with select pin as fault input, pulled low by another party
      bus(1'b1, OFS_CTRL_PRI, 8'hD0);
      ss_ext <= 1'b0;
      repeat (4) @(posedge clk_i);
      rdchk(OFS_STATUS, 8'h30);
      chk("fault irq", 8'h01, {7'h0, irq});
      ss_ext <= 1'b1;
      repeat (3) @(posedge clk_i);
      bus(1'b1, OFS_CTRL_PRI, 8'hD0);
      rdchk(OFS_STATUS, 8'h20);
      // one byte shifting, one queued, then disable
      bus(1'b0, OFS_STATUS, 8'h00);
      bus(1'b1, OFS_DATA, 8'hA5);
      bus(1'b0, OFS_STATUS, 8'h00);
      bus(1'b0, OFS_STATUS, 8'h00);
      bus(1'b1, OFS_DATA, 8'h5A);
      bus(1'b1, OFS_CTRL_PRI, 8'h12);
      pins();
      @(posedge clk_i);
      rdchk(OFS_STATUS, 8'h20);
      results();
   end
endmodule : spi_control_config_test
